/* File: rtl/hsi_pkg.sv */
package hsi_pkg;

  // ------------------------------------------------------------------
  // Descriptor store and register map
  // ------------------------------------------------------------------
  localparam int unsigned DW_N          = 8;
  localparam int unsigned DW_AW         = 3;
  localparam logic [11:0] OFF_DESC_LAST = 12'h01C;
  localparam logic [11:0] OFF_CTRL      = 12'h020;
  localparam logic [11:0] OFF_STAT      = 12'h024;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Descriptor dword indices and field positions
  // ------------------------------------------------------------------
  localparam logic [DW_AW-1:0] IDX_DW0 = 3'h0;
  localparam logic [DW_AW-1:0] IDX_DW1 = 3'h1;
  localparam logic [DW_AW-1:0] IDX_DW2 = 3'h2;
  localparam logic [DW_AW-1:0] IDX_DW3 = 3'h3;
  localparam logic [DW_AW-1:0] IDX_DW4 = 3'h4;

  localparam int unsigned POS_VALID   = 0;
  localparam int unsigned POS_EP0     = 31;
  localparam int unsigned POS_LEN_LO  = 3;
  localparam int unsigned POS_LEN_HI  = 17;
  localparam int unsigned POS_SPLIT   = 14;
  localparam int unsigned POS_KIND_LO = 12;
  localparam int unsigned POS_TOK_LO  = 10;
  localparam int unsigned POS_FADR_LO = 3;
  localparam int unsigned POS_EPH_LO  = 0;
  localparam int unsigned POS_BUF_LO  = 8;
  localparam int unsigned POS_RATE_LO = 3;
  localparam int unsigned POS_ACTIVE  = 31;
  localparam int unsigned POS_HALT    = 30;
  localparam int unsigned POS_TOGGLE  = 25;
  localparam int unsigned POS_CERR_LO = 23;
  localparam int unsigned POS_BYTES_LO = 0;
  localparam int unsigned POS_RES_LO  = 8;
  localparam int unsigned RES_W       = 3;

  localparam logic [1:0] KIND_INTERRUPT = 2'b11;
  localparam logic [1:0] TOKEN_OUT      = 2'b00;
  localparam logic [1:0] TOKEN_IN       = 2'b01;
  localparam logic [4:0] RATE_MIN       = 5'h01;
  localparam logic [4:0] RATE_UFRAME    = 5'h04;
  localparam logic [4:0] RATE_MAX       = 5'h09;

  typedef enum logic [3:0] {
    HSI_IDLE, HSI_FETCH, HSI_CAPT, HSI_CHECK, HSI_ISSUE, HSI_WB3, HSI_WB4, HSI_WB0
  } hsi_state_t;

endpackage

/* File: rtl/hsi_mem_if.sv */
`timescale 1ns/1ps
interface hsi_mem_if;
  import hsi_pkg::*;
  logic             we;
  logic [DW_AW-1:0] waddr;
  logic [31:0]      wdata;
  logic [DW_AW-1:0] raddr;
  logic [31:0]      rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: rtl/hsi_desc_mem.sv */
`timescale 1ns/1ps
module hsi_desc_mem (
  input wire logic mclk,   // System clock.
  hsi_mem_if.mem   port    // Descriptor store access.
);
  import hsi_pkg::*;

  logic [31:0] store_r [DW_N];
  logic [31:0] rdata_r;

  always_ff @(posedge mclk) begin
    if (port.we) begin
      store_r[port.waddr] <= port.wdata;
    end
    rdata_r <= store_r[port.raddr];
  end

  assign port.rdata = rdata_r;
endmodule

/* File: rtl/hsi_exec.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// R1: Keep eight 3-bit per-microframe result fields.
// R2: Result bits: error, babble on IN, underrun on OUT.
// R3: Issue only when frame matches and enable bit set.
// R4: Hardware clears enable bit after that microframe.
// R5: Enable patterns give every 1, 2 or 4 microframes.
// R6: Active flag mirrors valid; hardware updates it.
// R7: Set halt flag when the transaction halts.
// R8: Write back toggle expected for next transaction.
// R9: Two-bit error counter, decremented on errors.
// R10: Write back fifteen-bit transferred byte count.
// R11: Pass buffer pointer to the payload mover.
// R12: Poll every 2^(b-1) microframes, b 1 to 9.
// R13: Software keeps rate zero for b up to 4.
// R14: Split bit zero high-speed, one split.
// R15: Endpoint kind 11 means interrupt endpoint.
// R16: Token 00 sends OUT, 01 sends IN.
// R17: Address the seven-bit function address.
// R18: Endpoint number from DW1 bits and DW0 bit 31.
// R19: Clear valid when finished or on fatal error.
// R20: Unscheduled microframe results stay unchanged.
module hsi_exec (
  input  wire logic        mclk,            // System clock, 100 MHz.
  input  wire logic        reset,           // Synchronous reset, active high.
  input  wire logic [31:0] s_axi_awaddr,    // Write address.
  input  wire logic        s_axi_awvalid,   // Write address valid.
  output logic             s_axi_awready,   // Write address ready.
  input  wire logic [31:0] s_axi_wdata,     // Write data.
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes.
  input  wire logic        s_axi_wvalid,    // Write data valid.
  output logic             s_axi_wready,    // Write data ready.
  output logic [1:0]       s_axi_bresp,     // Write response.
  output logic             s_axi_bvalid,    // Write response valid.
  input  wire logic        s_axi_bready,    // Write response ready.
  input  wire logic [31:0] s_axi_araddr,    // Read address.
  input  wire logic        s_axi_arvalid,   // Read address valid.
  output logic             s_axi_arready,   // Read address ready.
  output logic [31:0]      s_axi_rdata,     // Read data.
  output logic [1:0]       s_axi_rresp,     // Read response.
  output logic             s_axi_rvalid,    // Read data valid.
  input  wire logic        s_axi_rready,    // Read data ready.
  input  wire logic        uframe_tick,     // Microframe start pulse.
  input  wire logic [2:0]  uframe_index,    // Current microframe 0 to 7.
  input  wire logic [10:0] frame_number,    // Current bus frame number.
  output logic             tok_valid,       // Transaction request to link.
  output logic             tok_pid_in,      // 1 for IN token, 0 for OUT.
  output logic [6:0]       tok_function_addr, // Target function address.
  output logic [3:0]       tok_endpoint_number, // Target endpoint.
  output logic             tok_toggle,      // Data toggle to use.
  output logic [15:0]      tok_buffer_pointer, // Internal payload address.
  output logic [14:0]      tok_length,      // Bytes to move.
  input  wire logic        res_valid,       // Transaction outcome pulse.
  input  wire logic        res_error,       // Transaction error.
  input  wire logic        res_babble,      // Babble seen on IN.
  input  wire logic        res_underrun,    // Underrun on OUT.
  input  wire logic [14:0] res_bytes        // Bytes moved.
);
  import hsi_pkg::*;

  // ------------------------------------------------------------------
  // Engine state
  // ------------------------------------------------------------------
  hsi_state_t       state_r, state_nxt;
  logic [DW_AW-1:0] idx_r;
  logic [2:0]       uf_r;
  logic [4:0]       frame_r;
  logic [31:0]      dw0_r, dw1_r, dw2_r, dw3_r, dw4_r;
  logic             r_err_r, r_bab_r, r_und_r;
  logic [14:0]      r_bytes_r;
  logic [31:0]      ctrl_r;
  hsi_mem_if        mem ();

  hsi_desc_mem u_mem (
    .mclk (mclk),
    .port (mem.mem)
  );

  // ------------------------------------------------------------------
  // Descriptor field decode
  // ------------------------------------------------------------------
  wire       f_valid   = dw0_r[POS_VALID];
  wire       f_active  = dw3_r[POS_ACTIVE];
  wire       f_halt    = dw3_r[POS_HALT];
  wire       f_split   = dw1_r[POS_SPLIT];
  wire [1:0] f_kind    = dw1_r[POS_KIND_LO +: 2];
  wire [1:0] f_token   = dw1_r[POS_TOK_LO +: 2];
  wire [4:0] f_rate    = dw2_r[POS_RATE_LO +: 5];
  wire [7:0] f_mask    = dw4_r[7:0];
  wire       f_toggle  = dw3_r[POS_TOGGLE];
  wire [1:0] f_cerr    = dw3_r[POS_CERR_LO +: 2];
  wire       token_ok  = (f_token == TOKEN_OUT) || (f_token == TOKEN_IN);

  // Slower rates select frames by matching the low frame bits under a
  // power-of-two mask; faster rates rely on the enable bits alone.
  // A zero rate field is how software asks for microframe polling.
  wire       rate_ok   = (f_rate <= RATE_MAX); // R13
  wire [4:0] per_mask  = 5'(6'(6'h01 << 3'(f_rate - RATE_UFRAME)) - 6'h01);
  wire       frame_hit = (f_rate <= RATE_UFRAME) ||
                         ((frame_r & per_mask) == (f_rate & per_mask)); // R12 R13
  wire       schedule  = f_valid && f_active && !f_halt && !f_split && // R6 R14
                         (f_kind == KIND_INTERRUPT) && token_ok && // R15
                         rate_ok && frame_hit && f_mask[uf_r]; // R3 R5

  // ------------------------------------------------------------------
  // Outcome and write-back values
  // ------------------------------------------------------------------
  // Babble is fatal at once; errors burn the counter and halt on the last.
  wire       fatal    = r_bab_r || (r_err_r && (f_cerr <= 2'b01)); // R7 R9
  wire       success  = !r_err_r && !r_bab_r && !r_und_r;
  wire [1:0] cerr_nxt = (r_err_r && (f_cerr != 2'b00)) ? 2'(f_cerr - 2'b01) : f_cerr; // R9
  wire [7:0] mask_nxt = f_mask & ~(8'h01 << uf_r); // R4
  wire       done     = fatal || (mask_nxt == 8'h00);
  wire [2:0] res_code = {r_und_r && !tok_pid_in, r_bab_r && tok_pid_in, r_err_r}; // R2
  wire [31:0] res_keep = ~({29'h0, 3'h7} << (POS_RES_LO + 3 * uf_r));

  logic [31:0] wb3, wb4, wb0;
  always_comb begin
    wb3 = dw3_r;
    wb3[POS_ACTIVE] = !done; // R6
    wb3[POS_HALT] = f_halt | fatal; // R7
    wb3[POS_TOGGLE] = f_toggle ^ success; // R8
    wb3[POS_CERR_LO +: 2] = cerr_nxt; // R9
    wb3[POS_BYTES_LO +: 15] = r_bytes_r; // R10
    // Only the current microframe's field is replaced.
    wb4 = (dw4_r & res_keep) |
          (32'(res_code) << (POS_RES_LO + 3 * uf_r)); // R1 R20
    wb4[7:0] = mask_nxt; // R4
    wb0 = dw0_r;
    wb0[POS_VALID] = !done; // R19
  end

  // ------------------------------------------------------------------
  // Engine sequencing
  // ------------------------------------------------------------------
  wire eng_idle = (state_r == HSI_IDLE);
  wire start    = eng_idle && uframe_tick && ctrl_r[0];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HSI_IDLE: begin
        if (start) state_nxt = HSI_FETCH;
      end
      HSI_FETCH: begin
        state_nxt = HSI_CAPT;
      end
      HSI_CAPT: begin
        state_nxt = (idx_r == IDX_DW4) ? HSI_CHECK : HSI_FETCH;
      end
      HSI_CHECK: begin
        state_nxt = schedule ? HSI_ISSUE : HSI_IDLE;
      end
      HSI_ISSUE: begin
        if (res_valid) state_nxt = HSI_WB3;
      end
      HSI_WB3: begin
        state_nxt = HSI_WB4;
      end
      HSI_WB4: begin
        state_nxt = HSI_WB0;
      end
      HSI_WB0: begin
        state_nxt = HSI_IDLE;
      end
      default: begin
        state_nxt = HSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= HSI_IDLE;
      idx_r   <= IDX_DW0;
      uf_r    <= 3'h0;
      frame_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        idx_r   <= IDX_DW0;
        uf_r    <= uframe_index;
        frame_r <= frame_number[4:0];
      end else if (state_r == HSI_CAPT) begin
        idx_r <= idx_r + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dw0_r <= 32'h0000_0000;
      dw1_r <= 32'h0000_0000;
      dw2_r <= 32'h0000_0000;
      dw3_r <= 32'h0000_0000;
      dw4_r <= 32'h0000_0000;
    end else if (state_r == HSI_CAPT) begin
      case (idx_r)
        IDX_DW0: dw0_r <= mem.rdata;
        IDX_DW1: dw1_r <= mem.rdata;
        IDX_DW2: dw2_r <= mem.rdata;
        IDX_DW3: dw3_r <= mem.rdata;
        default: dw4_r <= mem.rdata;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r_err_r   <= 1'b0;
      r_bab_r   <= 1'b0;
      r_und_r   <= 1'b0;
      r_bytes_r <= 15'h0000;
    end else if ((state_r == HSI_ISSUE) && res_valid) begin
      r_err_r   <= res_error;
      r_bab_r   <= res_babble;
      r_und_r   <= res_underrun;
      r_bytes_r <= res_bytes;
    end
  end

  // ------------------------------------------------------------------
  // Link request, held until the outcome arrives
  // ------------------------------------------------------------------
  assign tok_valid           = (state_r == HSI_ISSUE);
  assign tok_pid_in          = (f_token == TOKEN_IN); // R16
  assign tok_function_addr   = dw1_r[POS_FADR_LO +: 7]; // R17
  assign tok_endpoint_number = {dw1_r[POS_EPH_LO +: 3], dw0_r[POS_EP0]}; // R18
  assign tok_toggle          = f_toggle;
  assign tok_buffer_pointer  = dw2_r[POS_BUF_LO +: 16]; // R11
  assign tok_length          = dw0_r[POS_LEN_HI:POS_LEN_LO];

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  // Software is held off while the engine owns the store, so a
  // descriptor is never half rewritten under a running transaction.
  logic        bvalid_r, rvalid_r, rpend_r, rpend_mem_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [11:0] rd_off_r;

  wire [11:0] wr_off    = s_axi_awaddr[11:0];
  wire [11:0] ar_off    = s_axi_araddr[11:0];
  wire        wr_fire   = s_axi_awvalid && s_axi_wvalid && !bvalid_r && eng_idle && !start;
  wire        ar_fire   = s_axi_arvalid && !rvalid_r && !rpend_r && eng_idle && !start;
  wire        wr_hi_ok  = (s_axi_awaddr[31:12] == 20'h0_0000);
  wire        rd_hi_ok  = (s_axi_araddr[31:12] == 20'h0_0000);
  wire        wr_desc   = wr_hi_ok && (wr_off <= OFF_DESC_LAST) && (wr_off[1:0] == 2'b00);
  wire        wr_ctrl   = wr_hi_ok && (wr_off == OFF_CTRL);
  wire        wr_stat   = wr_hi_ok && (wr_off == OFF_STAT);
  wire        rd_desc   = rd_hi_ok && (ar_off <= OFF_DESC_LAST) && (ar_off[1:0] == 2'b00);
  wire        rd_ctrl   = rd_hi_ok && (ar_off == OFF_CTRL);
  wire        rd_stat   = rd_hi_ok && (ar_off == OFF_STAT);
  wire [31:0] wmask     = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] stat_word = {24'h00_0000, uf_r, 1'b0, 4'(state_r)};

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = ar_fire;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // Store port: engine reads and write-backs, or software accesses.
  wire eng_wr = (state_r == HSI_WB3) || (state_r == HSI_WB4) || (state_r == HSI_WB0);
  assign mem.we    = eng_wr || (wr_fire && wr_desc && (s_axi_wstrb == 4'hF));
  assign mem.waddr = (state_r == HSI_WB3) ? IDX_DW3 :
                     (state_r == HSI_WB4) ? IDX_DW4 :
                     (state_r == HSI_WB0) ? IDX_DW0 : wr_off[4:2];
  assign mem.wdata = (state_r == HSI_WB3) ? wb3 :
                     (state_r == HSI_WB4) ? wb4 :
                     (state_r == HSI_WB0) ? wb0 : s_axi_wdata;
  assign mem.raddr = eng_idle ? ar_off[4:2] : idx_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r   <= CTRL_RESET;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        // Partial writes to the store are refused: it has no byte lanes.
        bresp_r  <= (wr_ctrl || wr_stat || (wr_desc && (s_axi_wstrb == 4'hF))) ?
                    RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (wr_fire && wr_ctrl) begin
        ctrl_r <= (ctrl_r & ~wmask) | (s_axi_wdata & wmask & 32'h0000_0001);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rpend_r     <= 1'b0;
      rpend_mem_r <= 1'b0;
      rd_off_r    <= 12'h000;
      rvalid_r    <= 1'b0;
      rresp_r     <= RESP_OKAY;
      rdata_r     <= 32'h0000_0000;
    end else begin
      rpend_r <= ar_fire;
      if (ar_fire) begin
        rpend_mem_r <= rd_desc;
        rd_off_r    <= rd_ctrl ? OFF_CTRL : rd_stat ? OFF_STAT : 12'hFFF;
      end
      if (rpend_r) begin
        rvalid_r <= 1'b1;
        rresp_r  <= (rpend_mem_r || (rd_off_r != 12'hFFF)) ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rpend_mem_r ? mem.rdata :
                    (rd_off_r == OFF_CTRL) ? ctrl_r :
                    (rd_off_r == OFF_STAT) ? stat_word : 32'h0000_0000;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_issue_gate;
    @(posedge mclk) disable iff (reset)
    $rose(tok_valid) |-> f_mask[uf_r] && frame_hit && f_valid && !f_halt;
  endproperty
  a_issue_gate: assert property (p_issue_gate) else $error("token without enable"); // R3

  property p_hs_interrupt_only;
    @(posedge mclk) disable iff (reset)
    tok_valid |-> !f_split && (f_kind == KIND_INTERRUPT);
  endproperty
  a_hs_interrupt_only: assert property (p_hs_interrupt_only) else $error("bad kind"); // R14 R15

  property p_pid;
    @(posedge mclk) disable iff (reset)
    tok_valid |-> (tok_pid_in ? (dw1_r[POS_TOK_LO +: 2] == TOKEN_IN) :
                                (dw1_r[POS_TOK_LO +: 2] == TOKEN_OUT));
  endproperty
  a_pid: assert property (p_pid) else $error("wrong token pid"); // R16

  property p_target;
    @(posedge mclk) disable iff (reset)
    tok_valid |-> (tok_endpoint_number[0] == dw0_r[POS_EP0]) &&
                  (tok_function_addr == dw1_r[9:3]);
  endproperty
  a_target: assert property (p_target) else $error("wrong target"); // R17 R18

  property p_result_field;
    @(posedge mclk) disable iff (reset)
    (state_r == HSI_WB4) |-> (mem.wdata[POS_RES_LO + 3 * uf_r +: 3] == res_code) &&
                             mem.we && (mem.waddr == IDX_DW4);
  endproperty
  a_result_field: assert property (p_result_field) else $error("result lost"); // R1 R2

  property p_enable_clear;
    @(posedge mclk) disable iff (reset)
    (state_r == HSI_WB4) |-> !mem.wdata[uf_r] && ((mem.wdata[7:0] | f_mask) == f_mask);
  endproperty
  a_enable_clear: assert property (p_enable_clear) else $error("enable not cleared"); // R4

  property p_others_kept;
    @(posedge mclk) disable iff (reset)
    (state_r == HSI_WB4) |-> (((mem.wdata ^ dw4_r) & res_keep) >> 8) == 32'h0000_0000;
  endproperty
  a_others_kept: assert property (p_others_kept) else $error("other field changed"); // R20

  property p_toggle_next;
    @(posedge mclk) disable iff (reset)
    (state_r == HSI_ISSUE) && res_valid && !res_error && !res_babble && !res_underrun
      |=> (mem.wdata[POS_TOGGLE] != f_toggle) &&
          (mem.wdata[POS_BYTES_LO +: 15] == $past(res_bytes));
  endproperty
  a_toggle_next: assert property (p_toggle_next) else $error("toggle not flipped"); // R8 R10

  property p_babble_halts;
    @(posedge mclk) disable iff (reset)
    (state_r == HSI_ISSUE) && res_valid && res_babble
      |=> mem.wdata[POS_HALT] ##2 (mem.waddr == IDX_DW0) && !mem.wdata[POS_VALID];
  endproperty
  a_babble_halts: assert property (p_babble_halts) else $error("no halt"); // R7 R19
endmodule

/* File: tb/hsi_ep_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Device endpoint stand-in
// ------------------------------------------------------------------
module hsi_ep_model (
  input  wire logic        mclk,         // System clock.
  input  wire logic        tok_valid,    // Token offered by the host.
  input  wire logic [3:0]  delay,        // Cycles to wait before the answer.
  input  wire logic [2:0]  outcome,      // Underrun, babble, error to report.
  input  wire logic [14:0] bytes,        // Byte count to report.
  output logic             res_valid,    // Outcome strobe.
  output logic             res_error,    // Transaction error.
  output logic             res_babble,   // Babble seen.
  output logic             res_underrun, // Underrun seen.
  output logic [14:0]      res_bytes     // Bytes moved.
);
  logic [3:0] wait_cnt;

  initial begin
    wait_cnt = 4'h0;
    res_valid = 1'b0;
    {res_underrun, res_babble, res_error} = 3'h5;
    res_bytes = 15'h2AAA;
  end

  always @(posedge mclk) begin
    if (!res_valid && tok_valid === 1'b1 && wait_cnt == delay) begin
      res_valid <= 1'b1;
      {res_underrun, res_babble, res_error} <= outcome;
      res_bytes <= bytes;
      wait_cnt <= 4'h0;
    end else begin
      // Outside the strobe the lines mean nothing, so they keep changing.
      res_valid <= 1'b0;
      {res_underrun, res_babble, res_error} <= ~{res_underrun, res_babble, res_error};
      res_bytes <= ~res_bytes;
      if (tok_valid === 1'b1 && !res_valid) wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import hsi_pkg::*;
  typedef struct packed {
    logic [1:0] tok; logic sp; logic [1:0] kind; logic [7:0] mask; logic [2:0] idx;
    logic [2:0] oc; logic [1:0] cerr; logic dt;
    logic iss; logic [2:0] res; logic dto; logic halt; logic [1:0] cerro;
  } hsi_row_t;
  logic        mclk = 1'b0, reset = 1'b1, uframe_tick = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd, e4;
  logic [3:0]  s_axi_wstrb = '0, tok_endpoint_number, ep_delay = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  uframe_index = '0, ep_outcome = '0;
  logic [10:0] frame_number = '0;
  logic        tok_valid, tok_pid_in, tok_toggle, res_valid, res_error, res_babble;
  logic        res_underrun, seen, cap_pid, cap_dt, act;
  logic [6:0]  tok_function_addr;
  logic [15:0] tok_buffer_pointer;
  logic [14:0] tok_length, res_bytes, ep_bytes = '0;
  logic [7:0]  m;
  hsi_row_t    r;
  int          fails = 0, num_checks = 0, cycles = 0;
  localparam logic [14:0] LEN = 15'h0040;
  localparam hsi_row_t ROWS [10] = '{
    '{2'h0,1'h0,2'h3,8'hFF,3'h0,3'h0,2'h3,1'h0, 1'h1,3'h0,1'h1,1'h0,2'h3},
    '{2'h1,1'h0,2'h3,8'h55,3'h1,3'h0,2'h3,1'h1, 1'h0,3'h0,1'h1,1'h0,2'h3},
    '{2'h1,1'h0,2'h3,8'h55,3'h2,3'h2,2'h3,1'h1, 1'h1,3'h2,1'h1,1'h1,2'h3},
    '{2'h0,1'h0,2'h3,8'h11,3'h4,3'h4,2'h2,1'h0, 1'h1,3'h4,1'h0,1'h0,2'h2},
    '{2'h1,1'h0,2'h3,8'h80,3'h7,3'h1,2'h3,1'h0, 1'h1,3'h1,1'h0,1'h0,2'h2},
    '{2'h0,1'h0,2'h3,8'h08,3'h3,3'h1,2'h1,1'h1, 1'h1,3'h1,1'h1,1'h1,2'h0},
    '{2'h0,1'h0,2'h2,8'h01,3'h0,3'h0,2'h3,1'h0, 1'h0,3'h0,1'h0,1'h0,2'h3},
    '{2'h0,1'h1,2'h3,8'h01,3'h0,3'h0,2'h3,1'h0, 1'h0,3'h0,1'h0,1'h0,2'h3},
    '{2'h2,1'h0,2'h3,8'h01,3'h0,3'h0,2'h3,1'h0, 1'h0,3'h0,1'h0,1'h0,2'h3},
    '{2'h1,1'h0,2'h3,8'h01,3'h0,3'h0,2'h3,1'h1, 1'h1,3'h0,1'h0,1'h0,2'h3}};

  always #5 mclk = ~mclk;

  hsi_exec hsi_exec_inst (.*);
  hsi_ep_model hsi_ep_model_inst (.mclk(mclk), .tok_valid(tok_valid), .delay(ep_delay),
    .outcome(ep_outcome), .bytes(ep_bytes), .res_valid(res_valid), .res_error(res_error),
    .res_babble(res_babble), .res_underrun(res_underrun), .res_bytes(res_bytes));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Watches the token side long enough for the slowest answer and the write-back.
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (tok_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        cap_pid = tok_pid_in;
        cap_dt = tok_toggle;
        chk("target", {5'h00, 7'h5A, 4'hB, 16'h1234}, {5'h00, tok_function_addr,
          tok_endpoint_number, tok_buffer_pointer});
        chk("length", {17'h0_0000, LEN}, {17'h0_0000, tok_length});
      end
    end
  endtask

  task automatic tick(input logic [2:0] ix, input logic [10:0] fr);
    @(posedge mclk);
    uframe_tick <= 1'b1;
    uframe_index <= ix;
    frame_number <= fr;
    @(posedge mclk);
    uframe_tick <= 1'b0;
    watch(36);
  endtask

  task automatic load(input hsi_row_t x);
    axi_wr(32'h0000_0000, {1'b1, 13'h0000, LEN, 2'h0, 1'b1}, 4'hF);
    axi_wr(32'h0000_0004, {17'h0_0000, x.sp, x.kind, x.tok, 7'h5A, 3'h5}, 4'hF);
    axi_wr(32'h0000_0008, {8'h00, 16'h1234, 5'h00, 3'h0}, 4'hF);
    axi_wr(32'h0000_000C, {2'h2, 4'h0, x.dt, x.cerr, 8'h00, 15'h0000}, 4'hF);
    axi_wr(32'h0000_0010, {24'hFF_FFFF, x.mask}, 4'hF);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    chk("tok_valid", 32'h0000_0000, {31'h0, tok_valid});
    axi_rd(32'(OFF_CTRL));
    chk("ctrl", CTRL_RESET, rd);
    axi_rd(32'h0000_0100);
    chk("bad read resp", 32'(RESP_SLVERR), 32'(rsp));
    chk("bad read data", 32'h0000_0000, rd);
    axi_wr(32'h0000_0100, 32'h0000_0001, 4'hF);
    chk("bad write", 32'(RESP_SLVERR), 32'(rsp));
    axi_wr(32'h0000_0000, 32'h0000_0001, 4'h3);
    chk("part write", 32'(RESP_SLVERR), 32'(rsp));
    axi_wr(32'(OFF_CTRL), 32'h0000_0001, 4'hF);
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      load(r);
      ep_delay <= i[0] ? 4'h7 : 4'h0;
      ep_outcome <= r.oc;
      ep_bytes <= 15'h0100 + 15'(i);
      tick(r.idx, 11'(i * 37));
      chk("issued", 32'(r.iss), 32'(seen));
      if (r.iss) chk("pid dt", 32'({r.tok[0], r.dt}), 32'({cap_pid, cap_dt}));
      m = r.iss ? (r.mask & ~(8'h01 << r.idx)) : r.mask;
      act = !r.halt && (m != 8'h00);
      axi_rd(32'h0000_000C);
      chk("dw3", {act, r.halt, 4'h0, r.dto, r.cerro, 8'h00, r.iss ? ep_bytes : 15'h0000},
        rd & 32'hC380_7FFF);
      axi_rd(32'h0000_0010);
      e4 = {24'hFF_FFFF, m};
      if (r.iss) e4[8 + 3 * r.idx +: 3] = r.res;
      chk("dw4", e4, rd);
      axi_rd(32'h0000_0000);
      chk("valid", 32'(act), 32'(rd[0]));
    end
    r = ROWS[3];
    r.oc = 3'h0;
    load(r);
    ep_outcome <= 3'h0;
    for (int k = 0; k < 8; k++) begin
      tick(3'(k), 11'h005);
      chk("walk", 32'(k == 0 || k == 4), 32'(seen));
    end
    axi_rd(32'h0000_000C);
    chk("walk dw3", 32'h0000_0000, rd & 32'hC200_0000);
    axi_rd(32'h0000_0000);
    chk("walk valid", 32'h0000_0000, 32'(rd[0]));
    load(ROWS[0]);
    @(posedge mclk);
    uframe_tick <= 1'b1;
    @(posedge mclk);
    uframe_tick <= 1'b0;
    repeat (3) @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    watch(20);
    chk("reset token", 32'h0000_0000, 32'(seen));
    axi_rd(32'(OFF_CTRL));
    chk("reset ctrl", CTRL_RESET, rd);
    finish_test();
  end
endmodule
